// ---- verilog/iowdt_pkg.sv ----
// iowdt_pkg: constants of the I/O port watchdog timer
// assumes a 250 MHz system clock and a host I/O cycle decoded to one-cycle strobes
package iowdt_pkg;

   // port address and data
   localparam logic [15:0] WDT_PORT_ADDR    = 16'h0443;
   localparam int          IO_ADDR_W        = 16;
   localparam int          IO_DATA_W        = 8;
   localparam logic [7:0]  INTERVAL_MIN     = 8'h01;
   localparam logic [7:0]  INTERVAL_MAX     = 8'h3F;
   localparam logic [5:0]  INTERVAL_RST     = 6'h00;
   localparam int          INTERVAL_W       = 6;

   // time base
   localparam int          CLK_FREQ_HZ      = 250000000;
   localparam int          TICK_PERIOD_S    = 1;
   localparam int          TICK_CYCLES      = CLK_FREQ_HZ * TICK_PERIOD_S;
   localparam int          TICK_CNT_W       = 28;

   // expiry action, also the width of the interrupt pulse
   localparam int          IRQ_PULSE_CYCLES = 1;

   typedef enum logic [1:0] {
      IOWDT_IDLE,
      IOWDT_ARMED,
      IOWDT_FIRED
   } iowdt_state_t;

endpackage

// ---- verilog/iowdt_tick.sv ----
// iowdt_tick: divides the system clock down to a one-cycle pulse per second
// assumes clk_i at the package clock rate; restart_i realigns the second boundary
`timescale 1ns/10ps
module iowdt_tick #(
   parameter logic [27:0] TICK_CYCLES = 28'(iowdt_pkg::TICK_CYCLES)
)(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic restart_i,
   // time base
   output logic      tick_o
);

   logic [27:0] count;
   logic [27:0] next_count;
   logic        next_tick;

   always_comb
   begin
      next_count = count + 28'h0000001;
      next_tick  = 1'b0;
      if (restart_i)
      begin
         next_count = 28'h0000000;
      end
      else if (count == TICK_CYCLES - 28'h0000001)
      begin
         next_count = 28'h0000000;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count  <= 28'h0000000;
         tick_o <= 1'b0;
      end
      else
      begin
         count  <= next_count;
         tick_o <= next_tick;
      end
   end

endmodule

// ---- verilog/iowdt_top.sv ----
// iowdt_top: watchdog timer behind one byte-wide host I/O port
// assumes one-cycle read and write strobes with address and data valid alongside
`timescale 1ns/10ps
module iowdt_top #(
   parameter logic [27:0] TICK_CYCLES = 28'(iowdt_pkg::TICK_CYCLES)
)(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // host I/O cycle
   input  wire logic [15:0] io_addr_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_wdata_i,
   output logic      [7:0]  io_rdata_o,
   // configuration: high picks interrupt, low picks processor reset
   input  wire logic        expire_irq_sel_i,
   // expiry action and status
   output logic             cpu_reset_o,
   output logic             irq_o,
   output logic             armed_o
);

   ////////////////////////////////////////////////////////////////////////////
   // port decode

   logic hit;
   logic wr_hit;
   logic rd_hit;
   logic code_ok;

   assign hit     = (io_addr_i == iowdt_pkg::WDT_PORT_ADDR);
   assign wr_hit  = hit && io_wr_i;
   assign rd_hit  = hit && io_rd_i;
   // out-of-range codes only come from a misbehaving host; zero would wrap the countdown to 63 on the first tick
   assign code_ok = (io_wdata_i >= iowdt_pkg::INTERVAL_MIN) && (io_wdata_i <= iowdt_pkg::INTERVAL_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // one-second time base

   logic tick;
   logic restart;

   assign restart = wr_hit && code_ok;

   iowdt_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // countdown and expiry

   iowdt_pkg::iowdt_state_t state;
   iowdt_pkg::iowdt_state_t next_state;
   logic [5:0]              interval;
   logic [5:0]              next_interval;
   logic [5:0]              remain;
   logic [5:0]              next_remain;
   logic                    expire;
   logic                    action_irq;
   logic                    next_action_irq;
   logic                    next_cpu_reset;
   logic                    next_irq;
   logic [7:0]              next_rdata;

   always_comb
   begin
      next_state    = state;
      next_interval = interval;
      next_remain   = remain;
      expire        = 1'b0;
      case (state)
         iowdt_pkg::IOWDT_IDLE:
         begin
            // a read alongside the write keeps it disarmed, as it does when armed
            if (restart && !rd_hit)
            begin
               next_interval = io_wdata_i[5:0];
               next_remain   = io_wdata_i[5:0];
               next_state    = iowdt_pkg::IOWDT_ARMED;
            end
         end
         iowdt_pkg::IOWDT_ARMED:
         begin
            // a read in the same cycle as a write: disarm wins, host wants it stopped
            if (rd_hit)
            begin
               next_state = iowdt_pkg::IOWDT_IDLE;
            end
            else if (restart)
            begin
               next_interval = io_wdata_i[5:0];
               next_remain   = io_wdata_i[5:0];
            end
            else if (tick)
            begin
               if (remain == 6'h01)
               begin
                  next_remain = 6'h00;
                  expire      = 1'b1;
                  next_state  = iowdt_pkg::IOWDT_FIRED;
               end
               else
               begin
                  next_remain = remain - 6'h01;
               end
            end
         end
         iowdt_pkg::IOWDT_FIRED:
         begin
            if (rd_hit)
            begin
               next_state = iowdt_pkg::IOWDT_IDLE;
            end
            else if (restart)
            begin
               next_interval = io_wdata_i[5:0];
               next_remain   = io_wdata_i[5:0];
               next_state    = iowdt_pkg::IOWDT_ARMED;
            end
         end
         default:
         begin
            next_state = iowdt_pkg::IOWDT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state    <= iowdt_pkg::IOWDT_IDLE;
         interval <= iowdt_pkg::INTERVAL_RST;
         remain   <= iowdt_pkg::INTERVAL_RST;
      end
      else
      begin
         state    <= next_state;
         interval <= next_interval;
         remain   <= next_remain;
      end
   end

   assign armed_o = (state == iowdt_pkg::IOWDT_ARMED);

   ////////////////////////////////////////////////////////////////////////////
   // expiry action
   // interrupt is a pulse, reset a level; expiry only leaves armed, so set and clear never meet

   always_comb
   begin
      next_action_irq = action_irq;
      next_cpu_reset  = 1'b0;
      next_irq        = 1'b0;
      if (expire)
      begin
         next_action_irq = expire_irq_sel_i;
         next_cpu_reset  = !expire_irq_sel_i;
         next_irq        = expire_irq_sel_i;
      end
      else if ((state == iowdt_pkg::IOWDT_FIRED) && !rd_hit && !restart)
      begin
         // reset level holds until the host reads the port or writes it a code from 1 to 63
         next_cpu_reset = !action_irq;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         action_irq  <= 1'b0;
         cpu_reset_o <= 1'b0;
         irq_o       <= 1'b0;
      end
      else
      begin
         action_irq  <= next_action_irq;
         cpu_reset_o <= next_cpu_reset;
         irq_o       <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data

   always_comb
   begin
      next_rdata = io_rdata_o;
      if (rd_hit)
      begin
         next_rdata = {2'b00, interval};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         io_rdata_o <= 8'h00;
      end
      else
      begin
         io_rdata_o <= next_rdata;
      end
   end

endmodule

// ---- tb/iowdt_assertions.sv ----
// iowdt_assertions: port checks of the watchdog
// assumes a bind onto iowdt_top, one clock domain
`timescale 1ns/10ps
module iowdt_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [15:0] io_addr_i,
   input wire logic        io_wr_i,
   input wire logic        io_rd_i,
   input wire logic [7:0]  io_wdata_i,
   input wire logic [7:0]  io_rdata_o,
   input wire logic        expire_irq_sel_i,
   input wire logic        cpu_reset_o,
   input wire logic        irq_o,
   input wire logic        armed_o
);
   wire hit = io_addr_i == iowdt_pkg::WDT_PORT_ADDR;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence good_wr;
      hit && io_wr_i && !io_rd_i && io_wdata_i inside {[8'h01:8'h3F]};
   endsequence
   sequence port_rd;
      hit && io_rd_i;
   endsequence
   chk_write_arms: assert property (good_wr |=> armed_o) else $error("write did not arm");
   chk_read_disarms: assert property (port_rd |=> !armed_o && !cpu_reset_o && io_rdata_o[7:6] == 2'h0)
      else $error("read did not disarm");
   chk_arm_cause: assert property ($rose(armed_o) |-> $past(io_wr_i) && $past(hit))
      else $error("armed without a write");
   chk_fall_cause: assert property ($fell(armed_o) |-> ($past(io_rd_i) && $past(hit)) || cpu_reset_o || irq_o)
      else $error("disarmed without cause");
   chk_irq_pulse: assert property (irq_o |=> !irq_o) else $error("interrupt longer than one cycle");
   chk_irq_mode: assert property (irq_o |-> $past(expire_irq_sel_i) && $past(armed_o) && !cpu_reset_o)
      else $error("interrupt in wrong mode");
   chk_reset_mode: assert property ($rose(cpu_reset_o) |-> !$past(expire_irq_sel_i) && $past(armed_o))
      else $error("processor reset in wrong mode");
   chk_reset_hold: assert property ($fell(cpu_reset_o) |-> $past(hit) && ($past(io_rd_i) ||
      ($past(io_wr_i) && $past(io_wdata_i) inside {[8'h01:8'h3F]})))
      else $error("processor reset dropped early");
endmodule
////////////////////////////////////////
bind iowdt_top iowdt_chk u_iowdt_chk (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
   .io_rdata_o, .expire_irq_sel_i, .cpu_reset_o, .irq_o, .armed_o);

// ---- tb/iowdt_tb_top.sv ----
// iowdt_tb_top: self-checking bench for the port watchdog
// assumes design files compiled first; second shortened to TK cycles
`timescale 1ns/10ps
module iowdt_tb_top;
   localparam int TK = 10;
   logic        clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, sel = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic [7:0]  io_wdata_i = 8'h00, io_rdata_o;
   logic        cpu_reset_o, irq_o, armed_o;
   int          error_cnt = 0, checks_done = 0, seed = 11, model_q[$];
   iowdt_top #(.TICK_CYCLES(28'(TK))) u_iowdt_top (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
      .io_wdata_i, .io_rdata_o, .expire_irq_sel_i(sel), .cpu_reset_o, .irq_o, .armed_o);
   initial forever #2 clk_i = ~clk_i;
   ////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic io(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= wr;
      io_rd_i <= rd;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b0;
      if (wr && !rd && a == iowdt_pkg::WDT_PORT_ADDR && d inside {[1:63]})
         model_q.push_back(d);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // arm, check the exact expiry cycle, then read back and disarm
   task automatic expire(input int n);
      io(1'b1, 1'b0, iowdt_pkg::WDT_PORT_ADDR, 8'(n));
      step(1);
      chk("armed", 8'h01, {7'h00, armed_o});
      // the last tick is registered, so the action lands one edge after it
      step(n * TK - 1);
      chk("early", 8'h00, {6'h00, cpu_reset_o, irq_o});
      step(1);
      chk("action", sel ? 8'h01 : 8'h02, {6'h00, cpu_reset_o, irq_o});
      io(1'b0, 1'b1, iowdt_pkg::WDT_PORT_ADDR, 8'h00);
      step(1);
      chk("rdata", 8'(model_q[$]), io_rdata_o);
      chk("cleared", 8'h00, {6'h00, cpu_reset_o, armed_o});
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      step(1);
      chk("idle", 8'h00, {5'h00, cpu_reset_o, irq_o, armed_o});
      io(1'b1, 1'b0, iowdt_pkg::WDT_PORT_ADDR, 8'h40);
      io(1'b1, 1'b0, 16'h0043, 8'h05);
      step(1);
      chk("refused", 8'h00, {7'h00, armed_o});
      $display("test refusal done");
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk_i);
         sel <= i[0];
         expire(i == 0 ? 1 : i == 1 ? 63 : 1 + $unsigned($random(seed)) % 63);
      end
      $display("test expiry done");
      io(1'b1, 1'b0, iowdt_pkg::WDT_PORT_ADDR, 8'h02);
      step(15);
      expire(3);
      $display("test refresh done");
      // reset mode, so a missed disarm leaves a level that the check sees
      @(posedge clk_i);
      sel <= 1'b0;
      io(1'b1, 1'b0, iowdt_pkg::WDT_PORT_ADDR, 8'h05);
      step(20);
      io(1'b0, 1'b1, iowdt_pkg::WDT_PORT_ADDR, 8'h00);
      step(60);
      chk("disarmed", 8'h00, {5'h00, cpu_reset_o, irq_o, armed_o});
      chk("rdata", 8'(model_q[$]), io_rdata_o);
      $display("test disarm done");
      // reset held long enough that the disarm it causes stays inside the disabled span
      io(1'b1, 1'b0, iowdt_pkg::WDT_PORT_ADDR, 8'h07);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      model_q.push_back(int'(iowdt_pkg::INTERVAL_RST));
      step(1);
      chk("after reset", 8'h00, {5'h00, cpu_reset_o, irq_o, armed_o});
      io(1'b0, 1'b1, iowdt_pkg::WDT_PORT_ADDR, 8'h00);
      step(1);
      chk("rdata", 8'(model_q[$]), io_rdata_o);
      $display("test reset done");
      stop_test();
   end
   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end
endmodule
